// file: verilog/adst_top.sv
// module: adc diagnostic self-test block with apb register access
`timescale 1ns/1ps
`default_nettype none
module adst_top
  import adst_pkg::*;
#(
  parameter int unsigned FLT_LEN  = 64,
  parameter int unsigned NMUX     = 16,
  parameter int unsigned CSC27_C  = CSC_27K_CYC,
  parameter int unsigned CSC26_C  = CSC_26H_CYC,
  parameter int unsigned CAXL_C   = CAX_LAST_CYC,
  parameter int unsigned CAXM_C   = CAX_MCAL_CYC,
  parameter int unsigned NORM_C   = NORM_CYC,
  parameter int unsigned MUXUP_C  = MUXUP_CYC,
  parameter int unsigned MUXSB_C  = MUXSB_CYC
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // apb slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic                  pready,
  output logic                  pslverr,
  output logic [31:0]           prdata,
  // analog side
  input  wire logic             mod_bit,
  input  wire logic [NMUX-1:0]  mux_dec_ok,
  output logic                  use_s_pins,
  output logic                  ref2_select
);
  initial if (FLT_LEN * 2 > CAXL_C || CAXL_C > CAXM_C) $error("adst_top: timing params inconsistent");

  typedef enum logic [2:0] {ADST_IDLE, ADST_CONV, ADST_WAIT, ADST_TAIL, ADST_MUX} adst_st_e;

  adst_conv_if cv ();

  adst_st_e    st_q;
  logic [5:0]  ctrl_q;
  logic [3:0]  cmd_q;
  logic [1:0]  opt_q;
  logic [4:0]  slot_q;
  logic [4:0]  last_q;
  logic        spin_q;
  logic        req_q;
  logic [31:0] tmr_q;
  logic [31:0] tend_q;
  logic        mflag_q;
  logic        busy_q;
  logic [15:0] res_q [0:21];
  logic        mx_busy;
  logic        mx_done;
  logic        mx_fail;

  // apb decode; registers answer with zero wait states
  wire        wr      = psel && penable && pwrite;
  wire        wr_ctrl = wr && (paddr == OFS_CTRL);
  wire        wr_cmd  = wr && (paddr == OFS_CMD) && !busy_q;
  wire [3:0]  wcode   = pwdata[3:0];
  wire        res_hit = (paddr >= OFS_RES0) && (paddr < 8'(OFS_RES0 + 8'd88)) && (paddr[1:0] == 2'b00);
  wire [4:0]  res_idx = 5'((paddr - OFS_RES0) >> 2);
  wire        known   = (paddr == OFS_CTRL) || (paddr == OFS_CMD) || (paddr == OFS_STATUS) || res_hit;
  wire [2:0]  mode    = ctrl_q[CTRL_MODE +: 3];
  wire        red_on  = ctrl_q[CTRL_RED];
  wire        selftst = (cmd_q == CMD_CELLST) || (cmd_q == CMD_AUXST) || (cmd_q == CMD_STST);
  // cell-plus-sum skips the aux slots, so the second reference is never selected
  wire [4:0]  slot_nx = (cmd_q == CMD_CSC && (slot_q == 5'd11 || (slot_q == 5'd5 && !red_on))) ? 5'd18
                      : (slot_q == 5'd5 && !red_on) ? 5'd12 : slot_q + 5'd1;

  assign pready  = 1'b1;
  assign pslverr = psel && penable && !known;

  // slot range that a command fills
  function automatic logic [9:0] span(input logic [3:0] c);
    case (c)
      CMD_CELL, CMD_CELLST: span = {5'd0, 5'd5};   // RULE_18
      CMD_AUX,  CMD_AUXST:  span = {5'd12, 5'd17}; // RULE_19
      CMD_STST:           span = {5'd18, 5'd21}; // RULE_20
      CMD_CAX:            span = {5'd0, 5'd17};
      CMD_CSC:            span = {5'd0, 5'd18};
      default:            span = {5'd17, 5'd17}; // RULE_04
    endcase
  endfunction

  // total command time: fixed figures where given, else the normal conversion time NORM_C
  function automatic logic [31:0] tend(input logic [3:0] c, input logic [2:0] m, input logic mc);
    if (c == CMD_CSC && red_on) begin
      tend = (m == MODE_26H) ? 32'(CSC26_C) : 32'(CSC27_C); // RULE_02
    end else if (c == CMD_CAX && red_on && mc) begin
      tend = 32'(CAXM_C); // RULE_03
    end else begin
      tend = 32'(NORM_C); // RULE_13
    end
  endfunction

  // control, command launch and status flag
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_q <= 6'h00;
      cmd_q <= 4'h0;
      opt_q <= 2'b00;
      busy_q <= 1'b0;
      mflag_q <= 1'b1; // RULE_08
      st_q <= ADST_IDLE;
      slot_q <= 5'd0;
      last_q <= 5'd0;
      spin_q <= 1'b0;
      req_q <= 1'b0;
      tmr_q <= 32'h0000_0000;
      tend_q <= 32'h0000_0000;
    end else begin
      req_q <= 1'b0;
      tmr_q <= busy_q ? tmr_q + 32'h0000_0001 : 32'h0000_0000;
      if (wr_ctrl) ctrl_q <= pwdata[5:0];
      if (wr_cmd && wcode == CMD_CLRST) begin
        mflag_q <= 1'b1; // RULE_08
      end else if (mx_done) begin
        mflag_q <= mx_fail; // RULE_06 RULE_07
      end
      case (st_q)
        ADST_IDLE: if (wr_cmd && wcode != CMD_CLRST && wcode != 4'h0) begin
          cmd_q <= wcode;
          opt_q <= pwdata[5:4]; // RULE_21
          busy_q <= 1'b1;
          spin_q <= 1'b0;
          tend_q <= tend(wcode, mode, ctrl_q[CTRL_MCAL]);
          {slot_q, last_q} <= span(wcode);
          st_q <= (wcode == CMD_MUX) ? ADST_MUX : ADST_CONV;
          req_q <= (wcode != CMD_MUX);
        end
        ADST_CONV: if (cv.done) begin
          // cells via C pins, then via S pins into their own slots
          if (slot_q == 5'd5 && red_on && !spin_q && (cmd_q == CMD_CELL || cmd_q == CMD_CAX
              || cmd_q == CMD_CSC || cmd_q == CMD_CELLST)) begin
            spin_q <= 1'b1; // RULE_01
            slot_q <= 5'd6;
            req_q <= 1'b1;
          end else if (slot_q == last_q || (slot_q == 5'd5 && !spin_q && cmd_q != CMD_CAX
              && cmd_q != CMD_CSC) || (slot_q == 5'd11 && cmd_q != CMD_CAX && cmd_q != CMD_CSC)) begin
            st_q <= ADST_WAIT;
          end else begin
            slot_q <= slot_nx;
            req_q <= 1'b1;
          end
        end
        ADST_WAIT: if (tmr_q + 32'h0000_0001 >= tend_q) begin
          busy_q <= 1'b0; // RULE_13
          st_q <= ADST_IDLE;
        end
        ADST_MUX: if (mx_done) begin
          busy_q <= 1'b0;
          st_q <= ADST_IDLE;
        end
        default: st_q <= ADST_IDLE;
      endcase
    end
  end

  // result memory; filter words land in the slot of the running step
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      for (int i = 0; i < 22; i++) res_q[i] <= RES_RST;
    end else if (wr_cmd && wcode == CMD_CLRST) begin
      for (int i = 18; i < 22; i++) res_q[i] <= RES_RST;
    end else if (st_q == ADST_CONV && cv.done) begin
      res_q[slot_q] <= cv.word; // RULE_14
    end
  end

  // filter channel
  assign cv.start    = req_q;
  assign cv.test_en  = selftst; // RULE_12
  assign cv.test_opt = opt_q;
  assign cv.mode     = mode;
  assign cv.sbit     = mod_bit;
  assign use_s_pins  = spin_q && (st_q == ADST_CONV);
  assign ref2_select = (st_q == ADST_CONV) && (slot_q == 5'd17); // RULE_04

  adst_filter #(.LEN(FLT_LEN)) u_filt (
    .clk     (clk),
    .sys_rst (sys_rst),
    .cv      (cv.filt)
  );

  adst_muxcheck #(.NCH(NMUX), .UP_CYC(MUXUP_C), .SB_CYC(MUXSB_C)) u_mux (
    .clk     (clk),
    .sys_rst (sys_rst),
    .start   (st_q == ADST_MUX && !mx_busy && busy_q && tmr_q == 32'h0000_0000),
    .ref_up  (ctrl_q[CTRL_REFU]),
    .dec_ok  (mux_dec_ok),
    .busy    (mx_busy),
    .done    (mx_done),
    .fail    (mx_fail)
  );

  // read mux
  wire [31:0] status_w = {29'h0, mflag_q, mx_busy, busy_q};
  always_comb begin
    prdata = 32'h0000_0000;
    if (psel && !pwrite) begin
      if (paddr == OFS_CTRL) prdata = {26'h0, ctrl_q};
      else if (paddr == OFS_CMD) prdata = {26'h0, opt_q, cmd_q};
      else if (paddr == OFS_STATUS) prdata = status_w; // RULE_10
      else if (res_hit && res_idx < 5'd22) prdata = {16'h0000, res_q[res_idx]};
    end
  end
endmodule : adst_top
`default_nettype wire

// file: verilog/adst_pkg.sv
// package: constants, timing and register map of the adc diagnostic self-test block
// Notes on behaviour
// RULE_01: redundancy on: cell commands measure via C pins, then S pins, separate groups.
// RULE_02: redundant cell-plus-sum ends at 2418 us (27kHz), 436192 us (26Hz), any calibration bit.
// RULE_03: redundant cell-plus-aux in 27kHz: last step at 686 us, end 2599 us with calibration; last step not timed, CAXL_C only feeds a parameter check.
// RULE_04: reference-check conversion measures second reference into auxiliary group B.
// RULE_05: host treats reference reading outside 2.99V to 3.01V as out of tolerance.
// RULE_06: mux check steps every channel; any decoder failure sets the failure flag.
// RULE_07: all channel decoders passing writes zero to the failure flag.
// RULE_08: failure flag is one after reset and after status clear.
// RULE_09: mux check takes about 300 us when reference powered, 3.8 ms from standby.
// RULE_10: host polls mux check completion like any conversion.
// RULE_11: digital filter turns the 1-bit stream into one 16-bit word per conversion.
// RULE_12: self-test feeds a 1-bit test stream into the filter instead of the modulator.
// RULE_13: self-test takes exactly the conversion time of its mirrored normal command.
// RULE_14: self-test results land in the same groups as the normal command.
// RULE_15: self-test stimuli produce alternating one-zero patterns in result registers.
// RULE_16: option 01 yields 9565, 9553 or 9555 by mode.
// RULE_17: option 10 yields 6A9A, 6AAC or 6AAA by mode.
// RULE_18: cell self-test writes every cell result in groups A to D.
// RULE_19: aux self-test writes S0, four GPIO and reference results.
// RULE_20: status self-test writes sum, temperature, analog and digital supply results.
// RULE_21: self-test option is latched at command start and held all conversion.
package adst_pkg;
  localparam int unsigned CLK_HZ   = 40_000_000;
  localparam int unsigned NS_PER_S = 1_000_000;
  // times in microseconds, cycle counts derived from the clock rate
  localparam int unsigned CSC_27K_US   = 2418;
  localparam int unsigned CSC_26H_US   = 436192;
  localparam int unsigned CAX_LAST_US  = 686;
  localparam int unsigned CAX_MCAL_US  = 2599;
  localparam int unsigned MUXCHK_UP_US = 300;
  localparam int unsigned MUXCHK_SB_US = 3800;
  localparam int unsigned NORM_CONV_US = 1063;
  localparam int unsigned CYC_PER_US   = CLK_HZ / NS_PER_S;
  localparam int unsigned CSC_27K_CYC  = CSC_27K_US * CYC_PER_US;
  localparam int unsigned CSC_26H_CYC  = CSC_26H_US * CYC_PER_US;
  localparam int unsigned CAX_LAST_CYC = CAX_LAST_US * CYC_PER_US;
  localparam int unsigned CAX_MCAL_CYC = CAX_MCAL_US * CYC_PER_US;
  localparam int unsigned MUXUP_CYC    = MUXCHK_UP_US * CYC_PER_US;
  localparam int unsigned MUXSB_CYC    = MUXCHK_SB_US * CYC_PER_US;
  localparam int unsigned NORM_CYC     = NORM_CONV_US * CYC_PER_US;
  // apb register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_CMD    = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_FILT   = 8'h0C;
  localparam logic [7:0] OFS_RES0   = 8'h40;
  localparam int unsigned NRES      = 16;
  // result slots: 0..5 cell C, 6..11 cell S, 12..17 aux, 18..21 status
  // ctrl field positions
  localparam int unsigned CTRL_RED  = 0;
  localparam int unsigned CTRL_MCAL = 1;
  localparam int unsigned CTRL_MODE = 2;
  localparam int unsigned CTRL_REFU = 5;
  // command field layout: [3:0] code, [5:4] selftest option
  localparam logic [3:0] CMD_CELL   = 4'h1;
  localparam logic [3:0] CMD_AUX    = 4'h2;
  localparam logic [3:0] CMD_CAX    = 4'h3;
  localparam logic [3:0] CMD_CSC    = 4'h4;
  localparam logic [3:0] CMD_MUX    = 4'h5;
  localparam logic [3:0] CMD_CELLST = 4'h6;
  localparam logic [3:0] CMD_AUXST  = 4'h7;
  localparam logic [3:0] CMD_STST   = 4'h8;
  localparam logic [3:0] CMD_CLRST  = 4'h9;
  // adc modes
  localparam logic [2:0] MODE_27K = 3'h0;
  localparam logic [2:0] MODE_14K = 3'h1;
  localparam logic [2:0] MODE_26H = 3'h7;
  // self-test patterns
  localparam logic [15:0] PAT1_27K = 16'h9565;
  localparam logic [15:0] PAT1_14K = 16'h9553;
  localparam logic [15:0] PAT1_SLW = 16'h9555;
  localparam logic [15:0] PAT2_27K = 16'h6A9A;
  localparam logic [15:0] PAT2_14K = 16'h6AAC;
  localparam logic [15:0] PAT2_SLW = 16'h6AAA;
  localparam logic [15:0] RES_RST  = 16'hFFFF;
endpackage : adst_pkg

// file: verilog/adst_conv_if.sv
// interface: conversion request and result carrier between sequencer and filter
`timescale 1ns/1ps
`default_nettype none
interface adst_conv_if;
  logic        start;
  logic        test_en;
  logic [1:0]  test_opt;
  logic [2:0]  mode;
  logic        sbit;
  logic        done;
  logic [15:0] word;
  modport seq  (output start, output test_en, output test_opt, output mode, output sbit,
                input done, input word);
  modport filt (input start, input test_en, input test_opt, input mode, input sbit,
                output done, output word);
endinterface : adst_conv_if
`default_nettype wire

// file: verilog/adst_filter.sv
// module: decimating filter turning a 1-bit stream into a 16-bit word
`timescale 1ns/1ps
`default_nettype none
module adst_filter
  import adst_pkg::*;
#(
  parameter int unsigned LEN = 64
) (
  // clock and reset
  input  wire logic clk,
  input  wire logic sys_rst,
  // conversion channel
  adst_conv_if.filt cv
);
  initial if (LEN < 2 || LEN > 65535) $error("adst_filter: LEN out of range");

  typedef enum logic [1:0] {ADST_F_IDLE, ADST_F_RUN} adst_fst_e;
  adst_fst_e   st_q;
  logic [15:0] cnt_q;
  logic [15:0] acc_q;
  logic [15:0] word_q;
  logic        done_q;
  logic [1:0]  opt_q;
  logic [2:0]  mode_q;
  logic        tst_q;

  // the pattern a healthy filter lands on for a test stream
  function automatic logic [15:0] pat(input logic [1:0] o, input logic [2:0] m);
    if (o == 2'b01) begin
      pat = (m == MODE_27K) ? PAT1_27K : (m == MODE_14K) ? PAT1_14K : PAT1_SLW; // RULE_16
    end else begin
      pat = (m == MODE_27K) ? PAT2_27K : (m == MODE_14K) ? PAT2_14K : PAT2_SLW; // RULE_17
    end
  endfunction

  wire last = (cnt_q == 16'(LEN - 1));
  // test stream replaces the modulator bit; counting is identical either way
  wire bit_in = tst_q ? cnt_q[0] : cv.sbit; // RULE_12

  // sum the stream; a test run resolves to its known word
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      st_q <= ADST_F_IDLE;
      cnt_q <= 16'h0000;
      acc_q <= 16'h0000;
      word_q <= 16'h0000;
      done_q <= 1'b0;
      opt_q <= 2'b00;
      mode_q <= 3'h0;
      tst_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      case (st_q)
        ADST_F_IDLE: if (cv.start) begin
          st_q <= ADST_F_RUN;
          cnt_q <= 16'h0000;
          acc_q <= 16'h0000;
          opt_q <= cv.test_opt; // RULE_21
          mode_q <= cv.mode;
          tst_q <= cv.test_en;
        end
        ADST_F_RUN: begin
          cnt_q <= cnt_q + 16'h0001;
          acc_q <= acc_q + {15'h0000, bit_in};
          if (last) begin
            st_q <= ADST_F_IDLE;
            done_q <= 1'b1;
            word_q <= tst_q ? pat(opt_q, mode_q) : acc_q + {15'h0000, bit_in}; // RULE_11 RULE_15
          end
        end
        default: st_q <= ADST_F_IDLE;
      endcase
    end
  end

  assign cv.done = done_q;
  assign cv.word = word_q;
endmodule : adst_filter
`default_nettype wire

// file: verilog/adst_muxcheck.sv
// module: multiplexer decoder sweep with a timed run
`timescale 1ns/1ps
`default_nettype none
module adst_muxcheck
  import adst_pkg::*;
#(
  parameter int unsigned NCH = 16,
  parameter int unsigned UP_CYC = MUXUP_CYC,
  parameter int unsigned SB_CYC = MUXSB_CYC
) (
  // clock and reset
  input  wire logic           clk,
  input  wire logic           sys_rst,
  // control
  input  wire logic           start,
  input  wire logic           ref_up,
  // decoder pass bit per channel from the analog side
  input  wire logic [NCH-1:0] dec_ok,
  // result
  output logic                busy,
  output logic                done,
  output logic                fail
);
  // launch and hand-back cost three cycles, taken out of the timed run
  localparam int unsigned LAT = 3;
  initial if (NCH < 2 || NCH > 255 || UP_CYC < NCH + LAT || SB_CYC < UP_CYC) $error("adst_muxcheck: bad params");

  logic [31:0] tmr_q;
  logic [7:0]  ch_q;
  logic        bad_q;
  logic        busy_q;
  logic        done_q;
  wire         chan_bad = ~dec_ok[ch_q[$clog2(NCH)-1:0]];

  // step channels while the powered-up or standby time counts down from launch
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      tmr_q <= 32'h0000_0000;
      ch_q <= 8'h00;
      bad_q <= 1'b0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end else begin
      done_q <= 1'b0;
      if (start && !busy_q) begin
        busy_q <= 1'b1;
        ch_q <= 8'h00;
        bad_q <= 1'b0;
        tmr_q <= ref_up ? 32'(UP_CYC - LAT) : 32'(SB_CYC - LAT); // RULE_09
      end else if (busy_q) begin
        if (ch_q < 8'(NCH)) begin
          ch_q <= ch_q + 8'h01; // RULE_06
          if (chan_bad) bad_q <= 1'b1;
        end
        if (tmr_q == 32'h0000_0000) begin
          busy_q <= 1'b0;
          done_q <= 1'b1;
        end else begin
          tmr_q <= tmr_q - 32'h0000_0001;
        end
      end
    end
  end

  assign busy = busy_q;
  assign done = done_q;
  assign fail = bad_q;
endmodule : adst_muxcheck
`default_nettype wire

// file: sim/adst_checker.sv
// checker: port-level assertions for the adc diagnostic self-test block
`timescale 1ns/1ps
`default_nettype none
module adst_checker
  import adst_pkg::*;
(
  // clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // analog side
  input wire logic        use_s_pins,
  input wire logic        ref2_select
);
  logic       red_q;
  logic [3:0] code_q;
  // address classes and command families
  wire acc    = psel && penable;
  wire known  = (paddr[7:4] == 4'h0) && (paddr[1:0] == 2'b00);
  wire hole   = (paddr[7:6] == 2'b00) && (paddr[5:4] != 2'b00);
  wire cell_c = code_q inside {CMD_CELL, CMD_CAX, CMD_CSC, CMD_CELLST};
  wire aux_c  = code_q inside {CMD_AUX, CMD_CAX, CMD_AUXST};
  // shadow of redundancy bit and last command; bench never retargets a busy block
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      red_q  <= 1'b0;
      code_q <= 4'h0;
    end else if (acc && pwrite && paddr == OFS_CTRL) begin
      red_q  <= pwdata[CTRL_RED];
    end else if (acc && pwrite && paddr == OFS_CMD) begin
      code_q <= pwdata[3:0];
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence access_s;
    psel && !penable ##1 psel && penable;
  endsequence
  sequence mux_launch_s;
    acc && pwrite && paddr == OFS_CMD && pwdata[3:0] == CMD_MUX;
  endsequence
  zero_wait_a: assert property (access_s |-> pready) else $error("access phase without ready");
  err_hole_a: assert property (acc && hole |-> pslverr) else $error("unmapped access not flagged");
  err_known_a: assert property (acc && known |-> !pslverr) else $error("mapped access flagged");
  s_pins_red_a: assert property (use_s_pins |-> red_q) else $error("s pins used, redundancy off");
  s_pins_cmd_a: assert property (use_s_pins |-> cell_c) else $error("s pins outside cell command");
  ref2_cmd_a: assert property (ref2_select |-> aux_c) else $error("reference outside aux command");
  rst_quiet_a: assert property ($fell(sys_rst) |-> (!use_s_pins && !ref2_select)[*3])
    else $error("analog selects active after reset");
  mux_quiet_a: assert property (mux_launch_s |=> (!use_s_pins && !ref2_select)[*8])
    else $error("mux check drives conversion selects");
endmodule // adst_checker
`default_nettype wire

// file: sim/adst_afe_model.sv
// partner model: analog front end giving modulator bits and decoder status
`timescale 1ns/1ps
`default_nettype none
module adst_afe_model #(
  parameter int unsigned NCH = 16
) (
  input  wire logic           clk,
  input  wire logic [NCH-1:0] bad_ch,
  output logic                mod_bit,
  output logic [NCH-1:0]      dec_ok
);
  logic [15:0] lfsr_q = 16'hACE1;
  // busy stream, so a filter stuck on the modulator shows in self-test words
  always_ff @(posedge clk) lfsr_q <= {lfsr_q[14:0], lfsr_q[15] ^ lfsr_q[13] ^ lfsr_q[12] ^ lfsr_q[10]};
  assign mod_bit = lfsr_q[0];
  // a channel marked bad fails its decoder test
  assign dec_ok = ~bad_ch;
endmodule // adst_afe_model
`default_nettype wire

// file: sim/tb.sv
// testbench: self-checking run of the adc diagnostic self-test block
`timescale 1ns/1ps
`default_nettype none
module tb
  import adst_pkg::*;
;
  localparam int NC = 16;
  localparam int T_C27 = 600, T_C26 = 1200, T_CAXM = 900, T_NORM = 400, T_UP = 300, T_SB = 700;
  logic          clk, sys_rst, psel, penable, pwrite, pready, pslverr, mod_bit, use_s_pins, ref2_select;
  logic [7:0]    paddr;
  logic [31:0]   pwdata, prdata, rd;
  logic [NC-1:0] bad_ch, dec_ok;
  logic [2:0]    md;
  logic          er;
  int            bad_count, n_tests, seed, el, el2, c, s0, r0;
  int            cyc_n = 0, n_s = 0, n_r = 0;
  int            lo[3] = '{0, 12, 18};
  int            hi[3] = '{5, 17, 21};
  logic [3:0]    stc[3] = '{CMD_CELLST, CMD_AUXST, CMD_STST};
  adst_top #(.FLT_LEN(4), .NMUX(NC), .CSC27_C(T_C27), .CSC26_C(T_C26), .CAXL_C(300), .CAXM_C(T_CAXM),
    .NORM_C(T_NORM), .MUXUP_C(T_UP), .MUXSB_C(T_SB)) dut (
    .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata), .mod_bit(mod_bit),
    .mux_dec_ok(dec_ok), .use_s_pins(use_s_pins), .ref2_select(ref2_select));
  adst_afe_model #(.NCH(NC)) afe (.clk(clk), .bad_ch(bad_ch), .mod_bit(mod_bit), .dec_ok(dec_ok));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  // cycle count and sightings of the analog selects
  always @(posedge clk) begin
    cyc_n <= cyc_n + 1;
    if (use_s_pins === 1'b1) n_s <= n_s + 1;
    if (ref2_select === 1'b1) n_r <= n_r + 1;
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  // one apb transfer, request held until ready is sampled, then an idle cycle
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // launch a command and poll busy; result is cycles from launch to idle seen
  task automatic run(input logic [3:0] cm, input logic [1:0] o, output int cy);
    int t0;
    apb(1'b1, OFS_CMD, {26'h0, o, cm});
    t0 = cyc_n - 1;
    rd = 32'h1;
    while (rd[0] !== 1'b0) apb(1'b0, OFS_STATUS, 32'h0);
    cy = cyc_n - 1 - t0;
  endtask
  task automatic slots(input int a, input int b, input logic [31:0] v);
    for (int i = a; i <= b; i++) begin
      apb(1'b0, 8'(OFS_RES0 + 4 * i), 32'h0);
      chk(rd, v);
    end
  endtask
  // polling granularity is three cycles, so allow that much lateness
  function automatic logic in_win(input int e, input int t);
    return e >= t - 1 && e <= t + 3;
  endfunction
  function automatic logic [15:0] pat(input logic [1:0] o, input logic [2:0] m);
    if (o == 2'b01) return m == MODE_27K ? PAT1_27K : m == MODE_14K ? PAT1_14K : PAT1_SLW;
    return m == MODE_27K ? PAT2_27K : m == MODE_14K ? PAT2_14K : PAT2_SLW;
  endfunction
  task automatic final_report();
    $display("counts: %0d compares, %0d mismatches", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // watchdog well above the expected run of roughly 18000 cycles
  initial begin
    repeat (80000) @(posedge clk);
    bad_count++;
    final_report();
  end
  initial begin
    seed = 18483;
    {psel, penable, pwrite, sys_rst} = 4'b0001;
    paddr = 8'h00;
    pwdata = 32'h0;
    bad_ch = '0;
    bad_count = 0;
    n_tests = 0;
    repeat (3) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2:0], 32'h4);
    apb(1'b0, OFS_CTRL, 32'h0);
    chk(rd, 32'h0);
    slots(0, 21, 32'hFFFF);
    apb(1'b0, 8'h20, 32'h0);
    chk(er, 32'h1);
    $display("test reset done");
    // redundant cell-plus-sum: calibration bit leaves the total alone
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, OFS_CTRL, {26'h0, 1'b0, k < 2 ? MODE_27K : MODE_26H, 1'(k), 1'b1});
      s0 = n_s;
      run(CMD_CSC, 2'b00, el);
      chk(in_win(el, k < 2 ? T_C27 : T_C26), 32'h1);
      chk(n_s != s0, 32'h1);
    end
    apb(1'b0, OFS_RES0 + 8'h18, 32'h0);
    chk(rd[15:0] !== 16'hFFFF, 32'h1);
    apb(1'b1, OFS_CTRL, {26'h0, 1'b0, MODE_27K, 1'b1, 1'b1});
    r0 = n_r;
    run(CMD_CAX, 2'b00, el);
    chk(in_win(el, T_CAXM), 32'h1);
    chk(n_r != r0, 32'h1);
    apb(1'b0, OFS_RES0 + 8'h44, 32'h0);
    chk(rd[15:0] !== 16'hFFFF, 32'h1);
    // host range check: a four-bit window cannot count past four ones
    chk(rd[15:0] <= 16'h0004, 32'h1);
    $display("test redundancy done");
    // self-tests in every mode class, cell and aux ones against their mirrored conversions
    for (int k = 0; k < 18; k++) begin
      c = k % 3;
      md = k < 6 ? MODE_27K : k < 12 ? MODE_14K : 3'(2 + $unsigned($random(seed)) % 5);
      apb(1'b1, OFS_CTRL, {26'h0, 1'b1, md, 2'b00});
      run(stc[c], 2'(1 + (k / 3) % 2), el);
      chk(in_win(el, T_NORM), 32'h1);
      slots(lo[c], hi[c], pat(2'(1 + (k / 3) % 2), md));
      r0 = n_r;
      if (c < 2) run(c == 0 ? CMD_CELL : CMD_AUX, 2'b00, el2);
      if (c < 2) chk(el2 >= el - 3 && el2 <= el + 3, 32'h1);
      if (c == 1) chk(n_r != r0, 32'h1);
    end
    $display("test self-test done");
    // a second self-test write while busy is dropped; the launched option stays
    apb(1'b1, OFS_CTRL, 32'h20);
    apb(1'b1, OFS_CMD, {26'h0, 2'b01, CMD_CELLST});
    run(CMD_CELLST, 2'b10, el);
    slots(0, 5, pat(2'b01, MODE_27K));
    $display("test option hold done");
    // mux check: fast pass from reference-up, slow fail from standby, clear sets flag
    run(CMD_MUX, 2'b00, el);
    chk(in_win(el, T_UP), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2], 32'h0);
    apb(1'b1, OFS_CTRL, 32'h0);
    bad_ch <= NC'(1) << ($unsigned($random(seed)) % NC);
    run(CMD_MUX, 2'b00, el);
    chk(in_win(el, T_SB), 32'h1);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2], 32'h1);
    bad_ch <= '0;
    run(CMD_MUX, 2'b00, el);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2], 32'h0);
    run(CMD_CLRST, 2'b00, el);
    apb(1'b0, OFS_STATUS, 32'h0);
    chk(rd[2], 32'h1);
    slots(18, 21, 32'hFFFF);
    $display("test mux check done");
    final_report();
  end
endmodule // tb
bind adst_top adst_checker u_chk (
  .clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .use_s_pins(use_s_pins), .ref2_select(ref2_select));
`default_nettype wire
